// >>> vic_pkg.sv
/*
  Shared constants of the vectored interrupt controller: source positions,
  table addresses and reset values.
  Assumes a single system clock shared with the CPU core and all request sources.
*/
package vic_pkg;

  // ==========================================================================
  // source positions (position 0 is the most urgent)
  // ==========================================================================
  localparam int NUM_SRC = 23;
  localparam int IDX_W = 5;
  localparam logic [4:0] POS_LOW_VOLTAGE = 5'h00;
  localparam logic [4:0] POS_PIN_EDGE_0 = 5'h01;
  localparam logic [4:0] POS_PIN_EDGE_2 = 5'h03;
  localparam logic [4:0] POS_PIN_EDGE_3 = 5'h04;
  localparam logic [4:0] POS_PIN_EDGE_4 = 5'h05;
  localparam logic [4:0] POS_SERIAL_B_RX_ERR = 5'h07;
  localparam logic [4:0] POS_SERIAL_B_RX_END = 5'h08;
  localparam logic [4:0] POS_SERIAL_B_TX_END = 5'h09;
  localparam logic [4:0] POS_SHARED_SERIAL = 5'h0a;
  localparam logic [4:0] POS_TIMER_H_ONE = 5'h0b;
  localparam logic [4:0] POS_TIMER_H_ZERO = 5'h0c;
  localparam logic [4:0] POS_TIMER8_A = 5'h0d;
  localparam logic [4:0] POS_TIMER16_CH0 = 5'h0e;
  localparam logic [4:0] POS_TIMER16_CH1 = 5'h0f;
  localparam logic [4:0] POS_CONVERSION_END = 5'h10;
  localparam logic [4:0] POS_SERIAL_A_RX = 5'h11;
  localparam logic [4:0] POS_WATCH_INTERVAL = 5'h12;
  localparam logic [4:0] POS_TIMER8_B = 5'h13;
  // rom entry that carries the software break vector
  localparam logic [4:0] POS_BREAK = 5'h17;

  // positions 2, 6 and 20 to 22 have no source in this block
  localparam logic [22:0] USED_POS_MASK = 23'h0fffbb;
  // bit of request_flags_byte_b holding the shared serial flag
  localparam int SHARED_FLAG_BYTE_B_BIT = 2;

  // ==========================================================================
  // table addresses
  // ==========================================================================
  localparam logic [15:0] VEC_BASE = 16'h0004;
  localparam logic [15:0] VEC_STEP = 16'h0002;
  localparam logic [15:0] VEC_BREAK = 16'h003e;
  localparam logic [15:0] VEC_RESET = 16'h0000;

  // ==========================================================================
  // reset values
  // ==========================================================================
  localparam logic [22:0] FLAGS_RST = 23'h000000;
  localparam logic [3:0] RESET_CAUSE_RST = 4'h0;
  localparam logic [4:0] SEL_RST = 5'h00;

  typedef enum logic [1:0] {
    VIC_SRC_PIN,
    VIC_SRC_POWER_ON,
    VIC_SRC_LOW_VOLTAGE,
    VIC_SRC_WATCHDOG
  } vic_reset_src_t;

endpackage : vic_pkg

// >>> vic_vector_rom.sv
/*
  Vector table lookup: maps a source position to its table address.
  Assumes the address is stable from the controller's own clock domain.
*/
`timescale 1ns/1ps
module vic_vector_rom
  import vic_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [vic_pkg::IDX_W-1:0] addr_i,
  output logic [15:0] data_o
);

  // ==========================================================================
  // registered lookup
  // ==========================================================================
  logic [15:0] data_nxt;

  always_comb
  begin
    data_nxt = VEC_RESET;
    if (addr_i == POS_BREAK)
    begin
      data_nxt = VEC_BREAK;
    end
    else if (addr_i < 5'(NUM_SRC))
    begin
      // table address grows by one word per position
      data_nxt = VEC_BASE + 16'(addr_i) * VEC_STEP;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      data_o <= VEC_RESET;
    end
    else
    begin
      data_o <= data_nxt;
    end
  end

endmodule : vic_vector_rom

// >>> vic_controller.sv
/*
  Vectored interrupt controller top: request flags, two priority groups,
  fixed default order, nesting, software break, standby release, reset causes.
  Assumes request triggers, masks and the core handshake are on clk_i;
  only the external reset pin is asynchronous and is synchronised here.
*/
`timescale 1ns/1ps

// Overview of operation
// - two kinds: maskable requests under masks, and a software break interrupt.
// - each maskable request sits in the high or low group by its priority flag.
// - a high group request may interrupt service of a low group request.
// - simultaneous requests of one group are taken in fixed default order.
// - any unmasked pending request raises standby release for stop and halt.
// - break instruction raises a software interrupt even with interrupts disabled.
// - break bypasses priority groups and default order entirely.
// - four reset sources are recognised: pin, power-on, low voltage, watchdog.
// - positions 0,1,3,4,5 are low voltage and pin edges 0,2,3,4; 2,6 unused.
// - second serial unit error, receive end, transmit end at positions 7 to 9.
// - clocked serial end and first serial transmit end share position 10.
// - timer H1, timer H0 and timer 8a matches take positions 11 to 13.
// - 16-bit timer channels at 14, 15: match, or opposite pin edge when capturing.
// - conversion end takes position 16.
// - first serial receive end or receive error raise position 17.
// - watch interval request takes position 18.
// - timer 8b match takes position 19.
// - position 0 is most urgent and position 22 least urgent.
// - shared serial request sets one common flag, bit 2 of byte b.
// - the break interrupt uses table address 003e.
module vic_controller
  import vic_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic low_voltage_request_i,
  input wire logic pin_edge_request_0_i,
  input wire logic pin_edge_request_2_i,
  input wire logic pin_edge_request_3_i,
  input wire logic pin_edge_request_4_i,
  input wire logic serial_b_rx_error_request_i,
  input wire logic serial_b_rx_end_request_i,
  input wire logic serial_b_tx_end_request_i,
  input wire logic clocked_serial_end_request_i,
  input wire logic serial_a_tx_end_request_i,
  input wire logic timer_h_one_match_request_i,
  input wire logic timer_h_zero_match_request_i,
  input wire logic timer8_a_match_request_i,
  input wire logic timer16_ch0_match_i,
  input wire logic timer16_ch0_capture_mode_i,
  input wire logic timer16_ch0_opposite_edge_i,
  input wire logic timer16_ch1_match_i,
  input wire logic timer16_ch1_capture_mode_i,
  input wire logic timer16_ch1_opposite_edge_i,
  input wire logic conversion_end_request_i,
  input wire logic serial_a_rx_end_i,
  input wire logic serial_a_rx_error_i,
  input wire logic watch_interval_request_i,
  input wire logic timer8_b_match_request_i,
  input wire logic [vic_pkg::NUM_SRC-1:0] mask_i,
  input wire logic [vic_pkg::NUM_SRC-1:0] priority_low_i,
  input wire logic [vic_pkg::NUM_SRC-1:0] flag_clear_i,
  input wire logic int_enable_i,
  input wire logic break_instruction_i,
  input wire logic ack_i,
  input wire logic return_i,
  input wire logic reset_pin_n_i,
  input wire logic power_on_clear_i,
  input wire logic low_voltage_reset_i,
  input wire logic watchdog_overflow_i,
  input wire logic reset_cause_clear_i,
  output logic irq_o,
  output logic [15:0] vector_o,
  output logic [vic_pkg::IDX_W-1:0] source_o,
  output logic standby_release_o,
  output logic [vic_pkg::NUM_SRC-1:0] request_flags_o,
  output logic in_service_high_o,
  output logic in_service_low_o,
  output logic reset_request_o,
  output logic [3:0] reset_cause_o
);

  // ==========================================================================
  // triggers
  // ==========================================================================
  logic [NUM_SRC-1:0] trig;
  logic [NUM_SRC-1:0] flags_r;
  logic [NUM_SRC-1:0] flags_nxt;
  logic [NUM_SRC-1:0] ack_clr;
  logic [NUM_SRC-1:0] pend;
  logic [NUM_SRC-1:0] pend_high;
  logic [NUM_SRC-1:0] pend_low;
  logic irq_r;
  logic grp_low_r;
  logic brk_sel_r;
  logic brk_pend_r;
  logic svc_high_r;
  logic svc_low_r;
  logic [IDX_W-1:0] src_r;
  logic [IDX_W-1:0] sel_nxt;
  logic grp_low_nxt;
  logic brk_sel_nxt;
  logic irq_nxt;
  logic take;
  logic rst_pin_s1_r;
  logic rst_pin_s2_r;
  logic [3:0] reset_cause_r;
  logic [3:0] reset_evt;
  logic reset_req_r;
  logic standby_r;

  always_comb
  begin
    trig = '0;
    trig[POS_LOW_VOLTAGE] = low_voltage_request_i;
    trig[POS_PIN_EDGE_0] = pin_edge_request_0_i;
    trig[POS_PIN_EDGE_2] = pin_edge_request_2_i;
    trig[POS_PIN_EDGE_3] = pin_edge_request_3_i;
    trig[POS_PIN_EDGE_4] = pin_edge_request_4_i;
    trig[POS_SERIAL_B_RX_ERR] = serial_b_rx_error_request_i;
    trig[POS_SERIAL_B_RX_END] = serial_b_rx_end_request_i;
    trig[POS_SERIAL_B_TX_END] = serial_b_tx_end_request_i;
    trig[POS_SHARED_SERIAL] = clocked_serial_end_request_i | serial_a_tx_end_request_i;
    trig[POS_TIMER_H_ONE] = timer_h_one_match_request_i;
    trig[POS_TIMER_H_ZERO] = timer_h_zero_match_request_i;
    trig[POS_TIMER8_A] = timer8_a_match_request_i;
    trig[POS_TIMER16_CH0] = timer16_ch0_capture_mode_i ? timer16_ch0_opposite_edge_i
                                                       : timer16_ch0_match_i;
    trig[POS_TIMER16_CH1] = timer16_ch1_capture_mode_i ? timer16_ch1_opposite_edge_i
                                                       : timer16_ch1_match_i;
    trig[POS_CONVERSION_END] = conversion_end_request_i;
    trig[POS_SERIAL_A_RX] = serial_a_rx_end_i | serial_a_rx_error_i;
    trig[POS_WATCH_INTERVAL] = watch_interval_request_i;
    trig[POS_TIMER8_B] = timer8_b_match_request_i;
  end

  // ==========================================================================
  // request flags
  // ==========================================================================
  assign take = ack_i & irq_r;

  always_comb
  begin
    ack_clr = '0;
    if (take && !brk_sel_r)
    begin
      ack_clr[src_r] = 1'b1;
    end
  end

  // a trigger in the clearing cycle wins, so no event is lost
  assign flags_nxt = ((flags_r & ~(flag_clear_i | ack_clr)) | trig) & USED_POS_MASK;

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      flags_r <= FLAGS_RST;
    end
    else
    begin
      flags_r <= flags_nxt;
    end
  end

  // ==========================================================================
  // arbitration
  // ==========================================================================
  function automatic logic [IDX_W-1:0] vic_first_set(input logic [NUM_SRC-1:0] vec);
    logic [IDX_W-1:0] idx;
    idx = SEL_RST;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (vec[i])
      begin
        idx = IDX_W'(i);
      end
    end
    return idx;
  endfunction : vic_first_set

  assign pend = flags_r & ~mask_i;
  assign pend_high = pend & ~priority_low_i;
  assign pend_low = pend & priority_low_i;

  always_comb
  begin
    sel_nxt = SEL_RST;
    grp_low_nxt = 1'b0;
    brk_sel_nxt = 1'b0;
    irq_nxt = 1'b0;
    if (brk_pend_r)
    begin
      // break ignores enable, groups and order
      sel_nxt = POS_BREAK;
      brk_sel_nxt = 1'b1;
      irq_nxt = 1'b1;
    end
    else if (|pend_high)
    begin
      sel_nxt = vic_first_set(pend_high);
      irq_nxt = int_enable_i & ~svc_high_r;
    end
    else if (|pend_low)
    begin
      sel_nxt = vic_first_set(pend_low);
      grp_low_nxt = 1'b1;
      irq_nxt = int_enable_i & ~svc_high_r & ~svc_low_r;
    end
    // withdraw for one cycle after a take so a stale source is never offered
    if (take)
    begin
      irq_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      irq_r <= 1'b0;
      src_r <= SEL_RST;
      grp_low_r <= 1'b0;
      brk_sel_r <= 1'b0;
    end
    else
    begin
      irq_r <= irq_nxt;
      src_r <= sel_nxt;
      grp_low_r <= grp_low_nxt;
      brk_sel_r <= brk_sel_nxt;
    end
  end

  // ==========================================================================
  // break and in-service state
  // ==========================================================================
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      brk_pend_r <= 1'b0;
    end
    else
    begin
      brk_pend_r <= break_instruction_i | (brk_pend_r & ~(take & brk_sel_r));
    end
  end

  // one level per group; return retires the high level first
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      svc_high_r <= 1'b0;
      svc_low_r <= 1'b0;
    end
    else if (take && !brk_sel_r)
    begin
      if (grp_low_r)
      begin
        svc_low_r <= 1'b1;
      end
      else
      begin
        svc_high_r <= 1'b1;
      end
    end
    else if (return_i)
    begin
      if (svc_high_r)
      begin
        svc_high_r <= 1'b0;
      end
      else
      begin
        svc_low_r <= 1'b0;
      end
    end
  end

  vic_vector_rom u_rom (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .addr_i(sel_nxt),
    .data_o(vector_o)
  );

  // ==========================================================================
  // standby release and reset sources
  // ==========================================================================
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      standby_r <= 1'b0;
    end
    else
    begin
      // independent of the global enable: a wake-up must not need the core
      standby_r <= |pend;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rst_pin_s1_r <= 1'b1;
      rst_pin_s2_r <= 1'b1;
    end
    else
    begin
      rst_pin_s1_r <= reset_pin_n_i;
      rst_pin_s2_r <= rst_pin_s1_r;
    end
  end

  always_comb
  begin
    reset_evt = '0;
    reset_evt[VIC_SRC_PIN] = ~rst_pin_s2_r;
    reset_evt[VIC_SRC_POWER_ON] = power_on_clear_i;
    reset_evt[VIC_SRC_LOW_VOLTAGE] = low_voltage_reset_i;
    reset_evt[VIC_SRC_WATCHDOG] = watchdog_overflow_i;
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      reset_cause_r <= RESET_CAUSE_RST;
      reset_req_r <= 1'b0;
    end
    else
    begin
      reset_cause_r <= (reset_cause_r & ~{4{reset_cause_clear_i}}) | reset_evt;
      reset_req_r <= |reset_evt;
    end
  end

  assign irq_o = irq_r;
  assign source_o = src_r;
  assign standby_release_o = standby_r;
  assign request_flags_o = flags_r;
  assign in_service_high_o = svc_high_r;
  assign in_service_low_o = svc_low_r;
  assign reset_request_o = reset_req_r;
  assign reset_cause_o = reset_cause_r;

  // ==========================================================================
  // assertions
  // ==========================================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  a_set_wins_clear: assert property (
    (trig[POS_SHARED_SERIAL] && flag_clear_i[POS_SHARED_SERIAL]) |=> flags_r[POS_SHARED_SERIAL])
    else $error("trigger lost against clear");
  a_flag_holds: assert property ((flags_r[POS_TIMER8_B] && !flag_clear_i[POS_TIMER8_B]
    && !(take && src_r == POS_TIMER8_B && !brk_sel_r)) |=> flags_r[POS_TIMER8_B])
    else $error("flag dropped without clear");
  a_shared_flag: assert property (
    (clocked_serial_end_request_i || serial_a_tx_end_request_i)
    |=> flags_r[8 + SHARED_FLAG_BYTE_B_BIT]) else $error("shared flag not set");
  // a take in the cycle after the break withdraws the offer once, so require no take there
  a_break_taken: assert property ((break_instruction_i && !brk_pend_r && !take) ##1 !take
    |=> (irq_o && vector_o == VEC_BREAK)) else $error("break not offered");
  a_break_vector: assert property ((irq_o && brk_sel_r) |-> vector_o == VEC_BREAK)
    else $error("wrong break vector");
  a_vector_map: assert property ((irq_o && !brk_sel_r)
    |-> vector_o == VEC_BASE + {10'h000, src_r, 1'b0}) else $error("wrong vector");
  a_enable_needed: assert property ((irq_o && !brk_sel_r) |-> $past(int_enable_i)
    && ($past(pend) & (23'h1 << src_r)) != 23'h0)
    else $error("masked or disabled request offered");
  a_high_first: assert property ((irq_o && !brk_sel_r && grp_low_r)
    |-> $past(pend_high) == '0) else $error("low group beat high group");
  a_default_order: assert property ((irq_o && !brk_sel_r)
    |-> ((grp_low_r ? $past(pend_low) : $past(pend_high)) & ((23'h1 << src_r) - 23'h1)) == '0)
    else $error("default order broken");
  a_nest_high: assert property ((svc_low_r && !svc_high_r && int_enable_i && |pend_high
    && !brk_pend_r && !take) |=> irq_o && !grp_low_r) else $error("high did not nest");
  a_standby_wake: assert property ((|pend) |=> standby_release_o)
    else $error("no standby release");
  a_reset_cause: assert property ((watchdog_overflow_i || power_on_clear_i)
    |=> reset_request_o && (reset_cause_o[3] || !$past(watchdog_overflow_i))
    && (reset_cause_o[1] || !$past(power_on_clear_i))) else $error("reset source missed");

  c_break_disabled: cover property (break_instruction_i && !int_enable_i ##[1:2] irq_o);
  c_nesting: cover property (svc_low_r && take && !grp_low_r);
  c_simultaneous: cover property ($countones(pend) > 1 && irq_o);
  c_shared_source: cover property (serial_a_tx_end_request_i ##1 flags_r[POS_SHARED_SERIAL]);

endmodule : vic_controller

// >>> vic_core_model.sv
/*
  Behavioural model of the cpu core as seen by the interrupt controller.
  Assumes irq, vector and source are registered on clk_i by the controller.
*/
`timescale 1ns/1ps
module vic_core_model
  import vic_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic en_i,
  input wire logic [1:0] delay_i,
  input wire logic irq_i,
  input wire logic [15:0] vector_i,
  input wire logic [vic_pkg::IDX_W-1:0] source_i,
  output logic ack_o,
  output logic taken_o,
  output logic [15:0] vector_o,
  output logic [vic_pkg::IDX_W-1:0] source_o
);
  import vic_pkg::*;
  // ==========================================================================
  // acknowledge after delay_i + 1 cycles of a standing offer
  // ==========================================================================
  logic [1:0] wait_r;
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ack_o <= 1'b0;
      taken_o <= 1'b0;
      vector_o <= 16'h0000;
      source_o <= 5'h00;
      wait_r <= 2'h0;
    end
    else
    begin
      taken_o <= 1'b0;
      // ack held until seen together with irq; vector taken at that edge
      if (ack_o && irq_i)
      begin
        ack_o <= 1'b0;
        taken_o <= 1'b1;
        vector_o <= vector_i;
        source_o <= source_i;
        wait_r <= 2'h0;
      end
      else if (en_i && irq_i && !ack_o)
      begin
        if (wait_r == delay_i)
          ack_o <= 1'b1;
        else
          wait_r <= wait_r + 2'h1;
      end
      else if (!ack_o)
        wait_r <= 2'h0;
    end
  end
endmodule : vic_core_model

// >>> vic_controller_tb.sv
/*
  Self-checking bench of the interrupt controller with a core model.
  Assumes every request source and the core run on the single 125 MHz clock.
*/
`timescale 1ns/1ps
module vic_controller_tb;
  import vic_pkg::*;
  typedef struct {logic [4:0] pos; logic [15:0] vec;} vic_row_t;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [19:0] trig = '0;
  logic ch0_cap = 0, ch0_opp = 0, ch1_cap = 0, ch1_opp = 0;
  logic [22:0] mask = '0, prio_low = '1, fclr = '0;
  logic int_en = 1, break_instruction = 0, ret = 0, pin_n = 1, poc = 0, lvr = 0, wdo = 0, cclr = 0;
  logic core_en = 0;
  logic [1:0] core_dly = 2'h0;
  logic irq, sb, ish, isl, rreq, ack, taken;
  logic [15:0] vec, tvec;
  logic [4:0] src, tsrc;
  logic [22:0] flags;
  logic [3:0] cause;
  int n_fail = 0, n_checks = 0, cyc = 0;
  // trigger index i of trig drives the row's source
  vic_row_t rows [20] = '{'{5'h00, 16'h0004}, '{5'h01, 16'h0006}, '{5'h03, 16'h000a},
    '{5'h04, 16'h000c}, '{5'h05, 16'h000e}, '{5'h07, 16'h0012}, '{5'h08, 16'h0014},
    '{5'h09, 16'h0016}, '{5'h0a, 16'h0018}, '{5'h0a, 16'h0018}, '{5'h0b, 16'h001a},
    '{5'h0c, 16'h001c}, '{5'h0d, 16'h001e}, '{5'h0e, 16'h0020}, '{5'h0f, 16'h0022},
    '{5'h10, 16'h0024}, '{5'h11, 16'h0026}, '{5'h11, 16'h0026}, '{5'h12, 16'h0028},
    '{5'h13, 16'h002a}};

  always #4 clk_i = ~clk_i;

  vic_controller u_vic_controller (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .low_voltage_request_i(trig[0]), .pin_edge_request_0_i(trig[1]),
    .pin_edge_request_2_i(trig[2]), .pin_edge_request_3_i(trig[3]),
    .pin_edge_request_4_i(trig[4]), .serial_b_rx_error_request_i(trig[5]),
    .serial_b_rx_end_request_i(trig[6]), .serial_b_tx_end_request_i(trig[7]),
    .clocked_serial_end_request_i(trig[8]), .serial_a_tx_end_request_i(trig[9]),
    .timer_h_one_match_request_i(trig[10]), .timer_h_zero_match_request_i(trig[11]),
    .timer8_a_match_request_i(trig[12]), .timer16_ch0_match_i(trig[13]),
    .timer16_ch0_capture_mode_i(ch0_cap), .timer16_ch0_opposite_edge_i(ch0_opp),
    .timer16_ch1_match_i(trig[14]), .timer16_ch1_capture_mode_i(ch1_cap),
    .timer16_ch1_opposite_edge_i(ch1_opp), .conversion_end_request_i(trig[15]),
    .serial_a_rx_end_i(trig[16]), .serial_a_rx_error_i(trig[17]),
    .watch_interval_request_i(trig[18]), .timer8_b_match_request_i(trig[19]),
    .mask_i(mask), .priority_low_i(prio_low), .flag_clear_i(fclr), .int_enable_i(int_en),
    .break_instruction_i(break_instruction), .ack_i(ack), .return_i(ret), .reset_pin_n_i(pin_n),
    .power_on_clear_i(poc), .low_voltage_reset_i(lvr), .watchdog_overflow_i(wdo),
    .reset_cause_clear_i(cclr), .irq_o(irq), .vector_o(vec), .source_o(src),
    .standby_release_o(sb), .request_flags_o(flags), .in_service_high_o(ish),
    .in_service_low_o(isl), .reset_request_o(rreq), .reset_cause_o(cause));

  vic_core_model u_vic_core_model (.clk_i(clk_i), .reset_n_i(reset_n_i), .en_i(core_en),
    .delay_i(core_dly), .irq_i(irq), .vector_i(vec), .source_i(src), .ack_o(ack),
    .taken_o(taken), .vector_o(tvec), .source_o(tsrc));

  // ==========================================================================
  // tasks
  // ==========================================================================
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step

  task automatic chk(input string what, input logic [22:0] seen, input logic [22:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic pulse_trig(input logic [19:0] t);
    trig = t;
    step(1);
    trig = '0;
  endtask : pulse_trig

  task automatic pulse_ret();
    ret = 1'b1;
    step(1);
    ret = 1'b0;
    step(1);
  endtask : pulse_ret

  // waits a bounded time for the core model to take an offer
  task automatic take(input logic [15:0] v);
    int k;
    k = 0;
    while (taken !== 1'b1 && k < 40)
    begin
      step(1);
      k++;
    end
    chk("taken", taken, 1);
    chk("taken vector", tvec, v);
  endtask : take

  // hang guard: all tests need well under 2000 cycles
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      report_and_stop();
    end
  end

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial
  begin
    step(12);
    reset_n_i = 1'b1;
    chk("irq", irq, 0);
    chk("flags", flags, 0);
    chk("cause", cause, 0);
    $display("test reset done");
    core_en = 1'b1;
    foreach (rows[i])
    begin
      core_dly = 2'(i % 4);
      pulse_trig(20'h1 << i);
      chk("flag set", flags, 23'h1 << rows[i].pos);
      take(rows[i].vec);
      chk("source", tsrc, rows[i].pos);
      chk("flag taken", flags, 0);
      chk("low service", isl, 1);
      pulse_ret();
    end
    $display("test rows done");
    pulse_trig(20'hfffff);
    chk("all flags", flags, 23'h0fffbb);
    foreach (rows[i])
    begin
      if (i == 0 || rows[i].pos != rows[i - 1].pos)
      begin
        take(rows[i].vec);
        pulse_ret();
      end
    end
    $display("test default order done");
    prio_low = ~(23'h1 << 19);
    pulse_trig(20'h80001);
    take(16'h002a);
    chk("high service", ish, 1);
    pulse_ret();
    take(16'h0004);
    pulse_ret();
    $display("test groups done");
    prio_low = ~(23'h1 << 12);
    pulse_trig(20'h00010);
    take(16'h000e);
    pulse_trig(20'h00004);
    step(3);
    chk("low blocked", irq, 0);
    pulse_trig(20'h00800);
    take(16'h001c);
    chk("nested", {ish, isl}, 2'b11);
    break_instruction = 1'b1;
    step(1);
    break_instruction = 1'b0;
    take(16'h003e);
    chk("break source", tsrc, 23'h17);
    pulse_ret();
    pulse_ret();
    take(16'h000a);
    pulse_ret();
    $display("test nesting done");
    int_en = 1'b0;
    mask = ~(23'h1 << 16);
    pulse_trig(20'h08000);
    chk("standby early", sb, 0);
    step(1);
    chk("standby", sb, 1);
    chk("irq disabled", irq, 0);
    mask = '1;
    step(2);
    chk("standby masked", sb, 0);
    fclr = 23'h1 << 16;
    step(1);
    fclr = '0;
    chk("sw clear", flags, 0);
    break_instruction = 1'b1;
    step(1);
    break_instruction = 1'b0;
    take(16'h003e);
    $display("test standby and break done");
    core_en = 1'b0;
    ch0_cap = 1'b1;
    ch1_cap = 1'b1;
    pulse_trig(20'h06000);
    chk("capture ignores match", flags, 0);
    ch0_opp = 1'b1;
    ch1_opp = 1'b1;
    step(1);
    ch0_opp = 1'b0;
    ch1_opp = 1'b0;
    chk("capture edge", flags, 23'h00c000);
    $display("test capture done");
    poc = 1'b1;
    step(1);
    poc = 1'b0;
    chk("reset request", rreq, 1);
    chk("cause", cause, 4'h2);
    wdo = 1'b1;
    step(1);
    wdo = 1'b0;
    chk("cause", cause, 4'ha);
    lvr = 1'b1;
    step(1);
    lvr = 1'b0;
    chk("cause", cause, 4'he);
    cclr = 1'b1;
    step(1);
    cclr = 1'b0;
    chk("cause cleared", cause, 4'h0);
    pin_n = 1'b0;
    step(1);
    pin_n = 1'b1;
    step(2);
    chk("pin cause", cause, 4'h1);
    $display("test reset sources done");
    reset_n_i = 1'b0;
    step(1);
    chk("flags in reset", flags, 0);
    chk("cause in reset", cause, 0);
    reset_n_i = 1'b1;
    step(2);
    chk("flags after reset", flags, 0);
    chk("irq after reset", irq, 0);
    $display("test second reset done");
    report_and_stop();
  end
endmodule : vic_controller_tb
